/* File: shared/uhrc_pkg.sv */
/*
 * Package for the host run/stop control and status block: register
 * offsets, field positions, reset values, timing counts and types.
 * Assumes a 250 MHz system clock and a 16-bit word I/O register port.
 */
package uhrc_pkg;

    // Register byte offsets on the I/O port.
    localparam logic [7:0] CMD_OFS = 8'h00;
    localparam logic [7:0] STS_OFS = 8'h02;
    localparam logic [7:0] FRIDX_OFS = 8'h06;
    localparam logic [7:0] PRT_OFS = 8'h10;

    // Command register fields.
    localparam int CMD_RUN_BIT = 0;
    localparam int CMD_SRST_BIT = 1;
    localparam int CMD_BRST_BIT = 2;
    localparam int CMD_DBG_BIT = 5;

    // Status register fields.
    localparam int STS_PCIERR_BIT = 3;
    localparam int STS_PERR_BIT = 4;
    localparam int STS_HALT_BIT = 5;

    // Port status and control fields.
    localparam int PRT_CONN_BIT = 0;
    localparam int PRT_CCHG_BIT = 1;
    localparam int PRT_EN_BIT = 2;
    localparam int PRT_ECHG_BIT = 3;
    localparam int PRT_LS_BIT = 8;

    // Reset values.
    localparam logic [15:0] CMD_RST = 16'h0000;
    localparam logic [15:0] STS_RST = 16'h0000;
    localparam logic [10:0] FRIDX_RST = 11'h000;

    // Timing.
    localparam int CLK_PERIOD_NS = 4;
    localparam int FRAME_PERIOD_NS = 1000000;
    localparam int FRAME_CYCLES = FRAME_PERIOD_NS / CLK_PERIOD_NS;
    localparam int SRST_CYCLES = 4;

    typedef enum logic [1:0] {ST_HALTED, ST_RUN, ST_STOPPING} uhrc_state_e;

    // Status lines from the schedule engine.
    typedef struct packed {
        logic xact_busy;
        logic td_fetch;
        logic consist_err;
        logic pci_err;
    } uhrc_eng_s;

endpackage

/* File: logic/uhrc_run_ctrl.sv */
/*
 * Run/stop control, soft reset, bus-wide reset and status flags of a
 * host controller schedule engine, with the root port connect logic.
 * Assumes the schedule engine and port detectors are synchronous to
 * sys_clk_i and that registers are reached as 16-bit words.
 */
`timescale 1ns/1ps

module uhrc_run_ctrl
    import uhrc_pkg::*;
#(
    parameter int NPORTS = 2,
    parameter int FRAME_CNT = FRAME_CYCLES
)
(
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // Register port.
    input wire logic [7:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [15:0] io_wdata_i,
    output logic [15:0] io_rdata_o,
    // Schedule engine.
    input wire uhrc_eng_s eng_i,
    output logic eng_run_o,
    output logic xact_abort_o,
    output logic sof_restart_o,
    output logic [10:0] frame_index_o,
    output logic sys_hw_reset_o,
    output logic usb_bus_reset_o,
    // Root ports.
    input wire logic [NPORTS-1:0] connect_det_i,
    input wire logic [NPORTS-1:0] lowspeed_det_i,
    output logic [NPORTS-1:0] port_connect_o,
    output logic [NPORTS-1:0] port_enable_o,
    output logic [NPORTS-1:0] port_lowspeed_o
);

    localparam int FW = $clog2(FRAME_CNT + 1);

    uhrc_state_e state_r, state_nxt;
    logic run_r, dbg_r, brst_r, srst_r;
    logic [2:0] srst_cnt_r;
    logic halt_r, perr_r, pcierr_r;
    logic [FW-1:0] frm_cnt_r;
    logic [10:0] fridx_r;
    logic eng_run_r, abort_r, sof_r, sysrst_r;
    logic [15:0] rdata_r, rd_mux;
    logic [15:0] prt_word [NPORTS];

    wire wr_cmd = io_wr_i && (io_addr_i == CMD_OFS);
    wire wr_sts = io_wr_i && (io_addr_i == STS_OFS);
    wire wr_fridx = io_wr_i && (io_addr_i == FRIDX_OFS);
    wire srst_go = wr_cmd && io_wdata_i[CMD_SRST_BIT] && !srst_r;
    wire logic_clr = srst_r || brst_r;
    wire srst_end = srst_r && (srst_cnt_r == 3'(SRST_CYCLES - 1));
    wire in_run = (state_r == ST_RUN);
    wire fatal = in_run && (eng_i.consist_err || eng_i.pci_err);
    wire step_stop = in_run && dbg_r && eng_i.td_fetch;
    wire stop_done = !logic_clr && (state_r != ST_HALTED)
                     && (state_nxt == ST_HALTED);
    wire resume = !logic_clr && (state_r == ST_HALTED) && run_r;
    wire frm_tick = (frm_cnt_r == FW'(FRAME_CNT - 1));
    wire counting = (state_r != ST_HALTED);

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_HALTED:
                if (run_r)
                    state_nxt = ST_RUN;
            ST_RUN:
                if (!run_r)
                    state_nxt = eng_i.xact_busy ? ST_STOPPING : ST_HALTED;
            ST_STOPPING:
                if (!eng_i.xact_busy)
                    state_nxt = ST_HALTED;
            default:
                state_nxt = ST_HALTED;
        endcase
        if (logic_clr)
            state_nxt = ST_HALTED;
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_r <= ST_HALTED;
            eng_run_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            eng_run_r <= (state_nxt == ST_RUN);
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            run_r <= CMD_RST[CMD_RUN_BIT];
            dbg_r <= CMD_RST[CMD_DBG_BIT];
            brst_r <= CMD_RST[CMD_BRST_BIT];
            srst_r <= CMD_RST[CMD_SRST_BIT];
            srst_cnt_r <= 3'h0;
        end
        else
        begin
            if (logic_clr || fatal || step_stop)
                run_r <= 1'b0;
            else if (wr_cmd)
                run_r <= io_wdata_i[CMD_RUN_BIT];
            if (wr_cmd)
            begin
                dbg_r <= io_wdata_i[CMD_DBG_BIT];
                brst_r <= io_wdata_i[CMD_BRST_BIT];
            end
            if (srst_end)
                srst_r <= 1'b0;
            else if (srst_go)
                srst_r <= 1'b1;
            srst_cnt_r <= srst_r ? srst_cnt_r + 3'h1 : 3'h0;
        end
    end

    // Status flags: hardware set wins over a software clear.
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            halt_r <= STS_RST[STS_HALT_BIT];
            perr_r <= STS_RST[STS_PERR_BIT];
            pcierr_r <= STS_RST[STS_PCIERR_BIT];
        end
        else
        begin
            if (stop_done)
                halt_r <= 1'b1;
            else if (resume)
                halt_r <= 1'b0;
            else if (wr_sts && io_wdata_i[STS_HALT_BIT])
                halt_r <= 1'b0;
            perr_r <= (fatal && eng_i.consist_err)
                      || (perr_r && !(wr_sts && io_wdata_i[STS_PERR_BIT]));
            pcierr_r <= (fatal && eng_i.pci_err)
                        || (pcierr_r
                            && !(wr_sts && io_wdata_i[STS_PCIERR_BIT]));
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            frm_cnt_r <= '0;
            fridx_r <= FRIDX_RST;
        end
        else
        begin
            if (logic_clr || (stop_done && !dbg_r))
                frm_cnt_r <= '0;
            else if (counting)
                frm_cnt_r <= frm_tick ? '0 : frm_cnt_r + FW'(1);
            if (logic_clr)
                fridx_r <= FRIDX_RST;
            else if (wr_fridx && !run_r)
                fridx_r <= io_wdata_i[10:0];
            else if (counting && frm_tick)
                fridx_r <= fridx_r + 11'h001;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            abort_r <= 1'b0;
            sof_r <= 1'b0;
            sysrst_r <= 1'b0;
            rdata_r <= 16'h0000;
        end
        else
        begin
            abort_r <= srst_go;
            sof_r <= resume && !dbg_r;
            sysrst_r <= fatal;
            if (io_rd_i)
                rdata_r <= rd_mux;
        end
    end

    for (genvar i = 0; i < NPORTS; i++)
    begin : g_port
        logic conn_r, cchg_r, en_r, echg_r, ls_r;
        wire wr_p = io_wr_i && (io_addr_i == PRT_OFS + 8'(2 * i));
        always_ff @(posedge sys_clk_i or negedge nrst_i)
        begin
            if (!nrst_i)
            begin
                conn_r <= 1'b0;
                cchg_r <= 1'b0;
                en_r <= 1'b0;
                echg_r <= 1'b0;
                ls_r <= 1'b0;
            end
            else if (logic_clr)
            begin
                conn_r <= 1'b0;
                en_r <= 1'b0;
                echg_r <= 1'b1;
                ls_r <= 1'b0;
            end
            else
            begin
                conn_r <= connect_det_i[i];
                ls_r <= connect_det_i[i] && lowspeed_det_i[i];
                cchg_r <= (conn_r != connect_det_i[i])
                          || (cchg_r && !(wr_p && io_wdata_i[PRT_CCHG_BIT]));
                en_r <= connect_det_i[i]
                        && (wr_p ? io_wdata_i[PRT_EN_BIT] : en_r);
                echg_r <= (en_r && !connect_det_i[i])
                          || (echg_r && !(wr_p && io_wdata_i[PRT_ECHG_BIT]));
            end
        end
        assign prt_word[i] = {7'h00, ls_r, 4'h0, echg_r, en_r, cchg_r, conn_r};
        assign port_connect_o[i] = conn_r;
        assign port_enable_o[i] = en_r;
        assign port_lowspeed_o[i] = ls_r;
    end

    // Read selection; status shows only controller flags.
    always_comb
    begin
        rd_mux = 16'h0000;
        if (io_addr_i == CMD_OFS)
            rd_mux = {10'h000, dbg_r, 2'h0, brst_r, srst_r, run_r};
        else if (io_addr_i == STS_OFS)
            rd_mux = {10'h000, halt_r, perr_r, pcierr_r, 3'h0};
        else if (io_addr_i == FRIDX_OFS)
            rd_mux = {5'h00, fridx_r};
        for (int k = 0; k < NPORTS; k++)
            if (io_addr_i == PRT_OFS + 8'(2 * k))
                rd_mux = prt_word[k];
    end

    assign io_rdata_o = rdata_r;
    assign eng_run_o = eng_run_r;
    assign xact_abort_o = abort_r;
    assign sof_restart_o = sof_r;
    assign frame_index_o = fridx_r;
    assign sys_hw_reset_o = sysrst_r;
    assign usb_bus_reset_o = brst_r;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    property p_srst_clear;
        $rose(srst_r) |-> srst_r [*4] ##1 !srst_r;
    endproperty
    a_srst_clear: assert property (p_srst_clear)
        else $error("Soft reset bit did not clear after four cycles.");
    property p_abort;
        $rose(srst_r) |-> xact_abort_o ##1 !xact_abort_o;
    endproperty
    a_abort: assert property (p_abort)
        else $error("Soft reset did not abort the transaction.");
    property p_port_drop;
        $rose(srst_r) |=> port_connect_o == '0 && port_enable_o == '0
            && g_port[0].echg_r;
    endproperty
    a_port_drop: assert property (p_port_drop)
        else $error("Soft reset did not drop the ports.");
    property p_keep_run;
        (in_run && run_r && !logic_clr) |=> eng_run_o;
    endproperty
    a_keep_run: assert property (p_keep_run)
        else $error("Engine stopped while run bit was set.");
    property p_halt_set;
        stop_done |=> halt_r && !eng_run_o;
    endproperty
    a_halt_set: assert property (p_halt_set)
        else $error("Halted flag not set after stop.");
    property p_fatal;
        (fatal && eng_i.consist_err) |=> !run_r && perr_r && sys_hw_reset_o;
    endproperty
    a_fatal: assert property (p_fatal)
        else $error("Process error did not stop and reset.");
    property p_step;
        step_stop |=> !run_r ##1 !eng_run_o;
    endproperty
    a_step: assert property (p_step)
        else $error("Single step did not clear the run bit.");
    property p_frm_reset;
        (stop_done && !dbg_r) |=> frm_cnt_r == '0;
    endproperty
    a_frm_reset: assert property (p_frm_reset)
        else $error("Frame counter not reset on normal stop.");
    property p_frm_freeze;
        (state_r == ST_HALTED && dbg_r && !logic_clr) |=> $stable(frm_cnt_r);
    endproperty
    a_frm_freeze: assert property (p_frm_freeze)
        else $error("Frame counter moved while halted in debug.");
    property p_resume;
        resume |=> !halt_r ##0 sof_restart_o == !$past(dbg_r);
    endproperty
    a_resume: assert property (p_resume)
        else $error("Resume did not clear halted flag.");

endmodule

/* File: test/uhrc_dev_model.sv */
/*
 * Schedule engine and bus model facing the run control block.
 * Assumes one clock; the bench pulses the error requests.
 */
`timescale 1ns/1ps

module uhrc_dev_model
    import uhrc_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // From the control block and the bench.
    input wire logic run_i,
    input wire logic abort_i,
    input wire logic [3:0] busy_len_i,
    input wire logic consist_req_i,
    input wire logic pci_req_i,
    // To the control block.
    output uhrc_eng_s eng_o
);
    logic [3:0] cnt_r;
    logic start;

    assign start = run_i && (cnt_r == 4'h0);

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            cnt_r <= 4'h0;
        else if (abort_i)
            cnt_r <= 4'h0;
        else if (cnt_r != 4'h0)
            cnt_r <= cnt_r - 4'h1;
        else if (start)
            cnt_r <= busy_len_i;
    end

    assign eng_o.xact_busy = (cnt_r != 4'h0);
    assign eng_o.td_fetch = start;
    assign eng_o.consist_err = consist_req_i;
    assign eng_o.pci_err = pci_req_i;
endmodule

/* File: test/tb_uhrc_run_ctrl.sv */
/*
 * Self-checking bench for the run control block.
 * Assumes the block's own assertions and a model of the engine.
 */
`timescale 1ns/1ps

`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; \
    $display("wrong value at %0t: %h %h", $time, a, e); end end

module tb_uhrc_run_ctrl;
    import uhrc_pkg::*;
    logic sys_clk_i = 1'b0, nrst_i = 1'b0, io_wr_i = 1'b0, io_rd_i = 1'b0;
    logic [7:0] io_addr_i = 8'h00;
    logic [15:0] io_wdata_i = 16'h0000, io_rdata_o, v;
    uhrc_eng_s eng;
    logic eng_run_o, xact_abort_o, sof_restart_o, sys_hw_reset_o;
    logic usb_bus_reset_o, cons_r = 1'b0, pci_r = 1'b0;
    logic [10:0] frame_index_o;
    logic [1:0] connect_det_i = 2'b11, lowspeed_det_i = 2'b01;
    logic [1:0] port_connect_o, port_enable_o, port_lowspeed_o;
    logic [3:0] s;
    int fail_count = 0, checked = 0, cycles = 0;

    always #2 sys_clk_i = ~sys_clk_i;

    uhrc_run_ctrl #(.NPORTS(2), .FRAME_CNT(16)) u_uhrc_run_ctrl (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .io_addr_i(io_addr_i),
        .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i),
        .io_rdata_o(io_rdata_o), .eng_i(eng), .eng_run_o(eng_run_o),
        .xact_abort_o(xact_abort_o), .sof_restart_o(sof_restart_o),
        .frame_index_o(frame_index_o), .sys_hw_reset_o(sys_hw_reset_o),
        .usb_bus_reset_o(usb_bus_reset_o), .connect_det_i(connect_det_i),
        .lowspeed_det_i(lowspeed_det_i), .port_connect_o(port_connect_o),
        .port_enable_o(port_enable_o), .port_lowspeed_o(port_lowspeed_o));

    uhrc_dev_model u_uhrc_dev_model (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .run_i(eng_run_o),
        .abort_i(xact_abort_o), .busy_len_i(4'hF), .consist_req_i(cons_r),
        .pci_req_i(pci_r), .eng_o(eng));

    task automatic close_out;
        $display("checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            close_out();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        io_addr_i <= a;
        io_wdata_i <= d;
        io_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        io_wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk_i);
        io_addr_i <= a;
        io_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        io_rd_i <= 1'b0;
        #1 v = io_rdata_o;
    endtask

    // Records {sof, abort, system reset, any port disconnected}.
    // Sampling starts in the cycle of the calling edge, so that a
    // one-cycle pulse launched by that edge is seen.
    task automatic pulses;
        s = 4'h0;
        repeat (6)
        begin
            #1 s = s | {sof_restart_o, xact_abort_o, sys_hw_reset_o,
                port_connect_o != 2'b11};
            @(posedge sys_clk_i);
        end
    endtask

    task automatic wait_halt;
        v = 16'h0000;
        for (int i = 0; i < 40 && v[STS_HALT_BIT] !== 1'b1; i++)
            rd(STS_OFS);
        `CHK(v[STS_HALT_BIT], 1'b1)
    endtask

    task automatic t_run_stop;
        rd(STS_OFS);
        `CHK(v, STS_RST)
        wr(FRIDX_OFS, 16'h0123);
        rd(FRIDX_OFS);
        `CHK(v, 16'h0123)
        wr(CMD_OFS, 16'h0001);
        pulses();
        `CHK(s, 4'b1000)
        `CHK(eng_run_o, 1'b1)
        wr(FRIDX_OFS, 16'h0055);
        rd(FRIDX_OFS);
        `CHK(v == 16'h0055, 1'b0)
        rd(STS_OFS);
        `CHK(v[STS_HALT_BIT], 1'b0)
        wr(CMD_OFS, 16'h0000);
        rd(STS_OFS);
        `CHK(v[STS_HALT_BIT], 1'b0)
        `CHK(eng.xact_busy, 1'b1)
        `CHK(eng_run_o, 1'b0)
        wait_halt();
        `CHK(eng.xact_busy, 1'b0)
    endtask

    task automatic t_fatal(input int k);
        wr(CMD_OFS, 16'h0001);
        pulses();
        rd(STS_OFS);
        `CHK(v[STS_HALT_BIT], 1'b0)
        @(posedge sys_clk_i);
        cons_r <= (k == 0);
        pci_r <= (k == 1);
        @(posedge sys_clk_i);
        cons_r <= 1'b0;
        pci_r <= 1'b0;
        pulses();
        `CHK(s, 4'b0010)
        rd(CMD_OFS);
        `CHK(v[CMD_RUN_BIT], 1'b0)
        wait_halt();
        `CHK(v[4:3], (k == 0) ? 2'b10 : 2'b01)
        wr(STS_OFS, 16'h0000);
        rd(STS_OFS);
        `CHK(v[5:3] == 3'b000, 1'b0)
        wr(STS_OFS, 16'h0038);
        rd(STS_OFS);
        `CHK(v, 16'h0000)
    endtask

    task automatic t_step;
        wr(CMD_OFS, 16'h0020);
        wr(CMD_OFS, 16'h0021);
        wait_halt();
        rd(CMD_OFS);
        `CHK(v, 16'h0020)
        wr(CMD_OFS, 16'h0000);
    endtask

    task automatic t_soft_reset;
        wr(PRT_OFS, 16'h0004);
        #1 `CHK(port_enable_o, 2'b01)
        wr(CMD_OFS, 16'h0002);
        pulses();
        `CHK(s, 4'b0101)
        rd(CMD_OFS);
        `CHK(v[CMD_SRST_BIT], 1'b0)
        `CHK(port_connect_o, 2'b11)
        `CHK(port_lowspeed_o, 2'b01)
        `CHK(port_enable_o, 2'b00)
        rd(PRT_OFS);
        `CHK(v & 16'h010D, 16'h0109)
        rd(PRT_OFS + 8'h02);
        `CHK(v & 16'h010D, 16'h0009)
    endtask

    task automatic t_bus_reset;
        `CHK(usb_bus_reset_o, 1'b0)
        wr(CMD_OFS, 16'h0004);
        repeat (3) @(posedge sys_clk_i);
        #1 `CHK(usb_bus_reset_o, 1'b1)
        `CHK(port_connect_o, 2'b00)
        wr(CMD_OFS, 16'h0000);
        repeat (3) @(posedge sys_clk_i);
        #1 `CHK(usb_bus_reset_o, 1'b0)
    endtask

    task automatic t_chip_reset;
        wr(CMD_OFS, 16'h0001);
        pulses();
        `CHK(s, 4'b1000)
        nrst_i <= 1'b0;
        @(posedge sys_clk_i);
        #1 `CHK(usb_bus_reset_o, 1'b0)
        `CHK(eng_run_o, 1'b0)
        `CHK(port_connect_o, 2'b00)
        @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        rd(CMD_OFS);
        `CHK(v, CMD_RST)
    endtask

    initial
    begin
        repeat (4) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        t_run_stop();
        t_fatal(0);
        t_fatal(1);
        t_step();
        t_soft_reset();
        t_bus_reset();
        t_chip_reset();
        close_out();
    end
endmodule
